// >>> verilog/ddh_drive_if.sv
// Purpose: drive-side logic of the host port, register bus and data path
// Assumes: every pin input is asynchronous to core_clk
// Notes: open-collector outputs pull low while their enable is high
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// two-flop synchroniser with a chosen idle value
module ddh_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= INIT;
      q <= INIT;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module ddh_drive_if (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [ddh_pkg::BUS_W-1:0] host_data_bus_in,
  output logic [ddh_pkg::BUS_W-1:0] host_data_bus_out,
  output logic host_data_bus_oe,
  input wire logic [1:0] register_select_lines,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic host_reset_n,
  input wire logic [3:0] drive_select_n,
  input wire logic [2:0] head_select_n,
  input wire logic write_gate_n,
  input wire logic read_gate_n,
  input wire logic write_data,
  input wire logic write_clk_in,
  output logic write_clk_out,
  output logic write_clk_oe,
  input wire logic servo_clk,
  input wire logic servo_index,
  input wire logic data_recovery_oscillator_clk,
  input wire logic data_recovery_oscillator_data,
  input wire logic spindle_at_speed,
  input wire logic [1:0] sw_drive_addr,
  input wire logic [1:0] sw_sector_len,
  input wire logic sw_write_protect,
  input wire logic sw_wclk_from_drive,
  output logic ready_n_out,
  output logic ready_n_oe,
  output logic index_n_out,
  output logic index_n_oe,
  output logic sector_mark_n_out,
  output logic sector_mark_n_oe,
  output logic read_ref_clk,
  output logic read_data,
  output logic pll_acquire,
  output logic [2:0] head_sel,
  output logic write_current_en,
  output logic write_bit,
  output logic write_bit_stb,
  output logic spindle_run,
  output logic drive_fault
);
  import ddh_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // synchronised pins
  logic rd_n_s, wr_n_s, hrst_n_s, wg_n_s, rg_n_s;
  logic [3:0] dsel_n_s;
  logic [2:0] hsel_n_s;
  logic [BUS_W-1:0] bus_s;
  logic [1:0] rsel_s, addr_s, slen_s;
  logic wdata_s, wclk_s, sclk_s, sidx_s, dclk_s, ddata_s, speed_s;
  logic wprot_s, wcdir_s;

  ddh_sync #(.W(12), .INIT(12'hFFF)) u_sync_low (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .d({rd_n, wr_n, host_reset_n, drive_select_n, head_select_n,
        write_gate_n, read_gate_n}),
    .q({rd_n_s, wr_n_s, hrst_n_s, dsel_n_s, hsel_n_s, wg_n_s, rg_n_s})
  );

  ddh_sync #(.W(23), .INIT(23'h000000)) u_sync_high (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .d({host_data_bus_in, register_select_lines, write_data, write_clk_in,
        servo_clk, servo_index, data_recovery_oscillator_clk,
        data_recovery_oscillator_data, spindle_at_speed, sw_drive_addr,
        sw_sector_len, sw_write_protect, sw_wclk_from_drive}),
    .q({bus_s, rsel_s, wdata_s, wclk_s, sclk_s, sidx_s, dclk_s, ddata_s,
        speed_s, addr_s, slen_s, wprot_s, wcdir_s})
  );

  //////////////////////////////////////////////////////////////////////////////
  // selection and edge detection
  logic selected;
  logic wr_prev_r, hrst_prev_r, sclk_prev_r, sidx_prev_r, wclk_prev_r;
  logic wr_fall, hrst_fall, sclk_rise, sidx_rise, wclk_fall, wclk_src;
  logic hrst_act, rg_act, wg_act;
  logic ref_clk_r;

  assign selected = ~dsel_n_s[addr_s];
  assign wclk_src = wcdir_s ? ref_clk_r : wclk_s;
  assign wr_fall = wr_prev_r & ~wr_n_s & selected;
  assign hrst_fall = hrst_prev_r & ~hrst_n_s;
  assign hrst_act = ~hrst_n_s;
  assign sclk_rise = ~sclk_prev_r & sclk_s;
  assign sidx_rise = ~sidx_prev_r & sidx_s;
  assign wclk_fall = wclk_prev_r & ~wclk_src;
  assign rg_act = selected & ~rg_n_s;
  assign wg_act = selected & ~wg_n_s;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_prev_r <= 1'b1;
      hrst_prev_r <= 1'b1;
      sclk_prev_r <= 1'b0;
      sidx_prev_r <= 1'b0;
      wclk_prev_r <= 1'b0;
    end
    else
    begin
      wr_prev_r <= wr_n_s;
      hrst_prev_r <= hrst_n_s;
      sclk_prev_r <= sclk_s;
      sidx_prev_r <= sidx_s;
      wclk_prev_r <= wclk_src;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register writes and command decode
  logic cmd_wr;
  logic [BUS_W-1:0] cyl_tgt_r, cur_cyl_r;
  logic spun_r, fault_r, ready_r, skip_r, wr_bad;
  ddh_carr_t carr_r;

  assign cmd_wr = wr_fall & (rsel_s == REG_CMD);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      cyl_tgt_r <= CYL_RST;
    else if (hrst_act)
      cyl_tgt_r <= CYL_RST;
    else if (wr_fall && rsel_s == REG_CYL)
      cyl_tgt_r <= bus_s;
  end

  // spindle state survives a host reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      spun_r <= 1'b0;
    else if (cmd_wr && bus_s == CMD_SPIN_UP)
      spun_r <= 1'b1;
    else if (cmd_wr && bus_s == CMD_SPIN_DOWN)
      spun_r <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // carriage positioning
  logic [STEP_W-1:0] step_cnt_r;
  logic step_tick;

  assign step_tick = (step_cnt_r == STEP_W'(SEEK_STEP_CYC - 1));

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      step_cnt_r <= '0;
    else if (carr_r == CARR_IDLE || step_tick)
      step_cnt_r <= '0;
    else
      step_cnt_r <= step_cnt_r + STEP_W'(1);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      carr_r <= CARR_IDLE;
      cur_cyl_r <= CYL_RST;
    end
    else if (hrst_fall)
      carr_r <= spun_r ? CARR_RESTORE : CARR_IDLE;
    else
    begin
      unique case (carr_r)
        CARR_IDLE:
        begin
          if (cmd_wr && bus_s == CMD_RESTORE)
            carr_r <= CARR_RESTORE;
          else if (cmd_wr && bus_s == CMD_SEEK && ready_r)
            carr_r <= CARR_SEEK;
        end
        CARR_SEEK:
        begin
          if (step_tick)
          begin
            if (cur_cyl_r == cyl_tgt_r)
              carr_r <= CARR_IDLE;
            else if (cur_cyl_r < cyl_tgt_r)
              cur_cyl_r <= cur_cyl_r + BUS_W'(1);
            else
              cur_cyl_r <= cur_cyl_r - BUS_W'(1);
          end
        end
        CARR_RESTORE:
        begin
          if (step_tick)
          begin
            if (cur_cyl_r == CYL_RST)
              carr_r <= CARR_IDLE;
            else
              cur_cyl_r <= cur_cyl_r - BUS_W'(1);
          end
        end
        default:
          carr_r <= CARR_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // ready and fault
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ready_r <= 1'b0;
    else
      ready_r <= spun_r & speed_s & (carr_r == CARR_IDLE) & ~fault_r
                 & ~(cmd_wr && bus_s == CMD_SEEK);
  end

  assign wr_bad = ~ready_r | wprot_s | skip_r | rg_act;

  // a new fault wins over the clear command in the same cycle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      fault_r <= 1'b0;
    else if (wg_act && wr_bad)
      fault_r <= 1'b1;
    else if (hrst_act || (cmd_wr && bus_s == CMD_FAULT_CLR))
      fault_r <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // index, sector marks and the protected skip area
  logic [SECT_W-1:0] sect_cnt_r, sect_len;
  logic [PULSE_W-1:0] idx_pulse_r, sm_pulse_r;
  logic sect_hit;

  always_comb
  begin
    unique case (slen_s)
      2'h0: sect_len = SECT_LEN_0;
      2'h1: sect_len = SECT_LEN_1;
      2'h2: sect_len = SECT_LEN_2;
      2'h3: sect_len = SECT_LEN_3;
    endcase
  end

  // index opens sector zero itself; no mark at the index
  assign sect_hit = sclk_rise && !sidx_rise
                    && (sect_cnt_r == sect_len - SECT_W'(1));

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      sect_cnt_r <= '0;
    else if (sidx_rise || sect_hit)
      sect_cnt_r <= '0;
    else if (sclk_rise)
      sect_cnt_r <= sect_cnt_r + SECT_W'(1);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      idx_pulse_r <= '0;
    else if (sidx_rise)
      idx_pulse_r <= PULSE_W'(MARK_PULSE_CYC);
    else if (idx_pulse_r != '0)
      idx_pulse_r <= idx_pulse_r - PULSE_W'(1);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      sm_pulse_r <= '0;
    else if (sect_hit)
      sm_pulse_r <= PULSE_W'(MARK_PULSE_CYC);
    else if (sm_pulse_r != '0)
      sm_pulse_r <= sm_pulse_r - PULSE_W'(1);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      skip_r <= 1'b0;
    else if (sidx_rise)
      skip_r <= 1'b1;
    else if (sect_hit)
      skip_r <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // read gate, reference clock and read data
  logic [RG_CNT_W-1:0] rg_cnt_r;
  logic use_dro, rd_valid;

  assign use_dro = (rg_cnt_r >= RG_CNT_W'(RG_SWITCH_CYC));
  assign rd_valid = (rg_cnt_r == RG_CNT_W'(RD_VALID_CYC));

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rg_cnt_r <= '0;
    else if (!rg_act)
      rg_cnt_r <= '0;
    else if (!rd_valid)
      rg_cnt_r <= rg_cnt_r + RG_CNT_W'(1);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_clk_r <= 1'b0;
      read_data <= 1'b0;
      pll_acquire <= 1'b0;
    end
    else
    begin
      ref_clk_r <= use_dro ? dclk_s : sclk_s;
      read_data <= rd_valid & ddata_s;
      pll_acquire <= rg_act;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // head select and write path
  logic [2:0] head_code;

  assign head_code = ~hsel_n_s;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      head_sel <= HEAD_DEFAULT;
    else if (selected)
      head_sel <= (head_code > HEAD_MAX) ? HEAD_DEFAULT : head_code;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      write_current_en <= 1'b0;
      write_bit <= 1'b0;
      write_bit_stb <= 1'b0;
    end
    else
    begin
      write_current_en <= wg_act & ~wr_bad & ~fault_r;
      write_bit_stb <= wclk_fall & write_current_en;
      if (wclk_fall)
        write_bit <= wdata_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register read port
  logic [BUS_W-1:0] status_byte, rd_mux;

  always_comb
  begin
    status_byte = BUS_ZERO;
    status_byte[ST_READY] = ready_r;
    status_byte[ST_FAULT] = fault_r;
    status_byte[ST_SEEK] = (carr_r != CARR_IDLE);
    status_byte[ST_SPUN] = spun_r;
    status_byte[ST_WPROT] = wprot_s;
    status_byte[ST_RDVALID] = rd_valid;
  end

  always_comb
  begin
    unique case (rsel_s)
      REG_CMD: rd_mux = status_byte;
      REG_CYL: rd_mux = cyl_tgt_r;
      REG_POS: rd_mux = cur_cyl_r;
      default: rd_mux = BUS_ZERO;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      host_data_bus_out <= BUS_ZERO;
      host_data_bus_oe <= 1'b0;
    end
    else
    begin
      host_data_bus_out <= rd_mux;
      host_data_bus_oe <= selected & ~rd_n_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin outputs
  assign read_ref_clk = ref_clk_r;
  assign write_clk_out = ref_clk_r;
  assign write_clk_oe = wcdir_s;
  assign ready_n_out = 1'b0;
  assign ready_n_oe = selected & ready_r;
  assign index_n_out = 1'b0;
  assign index_n_oe = selected & (idx_pulse_r != '0);
  assign sector_mark_n_out = 1'b0;
  assign sector_mark_n_oe = selected & (sm_pulse_r != '0);
  assign spindle_run = spun_r;
  assign drive_fault = fault_r;

endmodule

// >>> common/ddh_pkg.sv
// Purpose: constants and types for the drive-side host port logic
// Assumes: core clock of 10 MHz; all host pins arrive asynchronously
// Notes: times are kept in ns and turned into clock counts here
package ddh_pkg;

  localparam int BUS_W = 8;
  localparam int CLK_PERIOD_NS = 100;

  // all times round up to whole clock counts
  localparam int RG_SWITCH_NS = 6000;
  localparam int RG_SWITCH_CYC =
    (RG_SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_VALID_NS = 9000;
  localparam int RD_VALID_CYC =
    (RD_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEEK_STEP_NS = 3000;
  localparam int SEEK_STEP_CYC =
    (SEEK_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MARK_PULSE_NS = 200;
  localparam int MARK_PULSE_CYC =
    (MARK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int RG_CNT_W = 8;
  localparam int STEP_W = 8;
  localparam int PULSE_W = 4;
  localparam int SECT_W = 16;

  // register indices on the select lines
  localparam logic [1:0] REG_CMD = 2'h0;
  localparam logic [1:0] REG_CYL = 2'h1;
  localparam logic [1:0] REG_POS = 2'h2;

  // status byte bit positions
  localparam int ST_READY = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_SEEK = 2;
  localparam int ST_SPUN = 3;
  localparam int ST_WPROT = 4;
  localparam int ST_RDVALID = 5;

  localparam logic [BUS_W-1:0] CYL_RST = 8'h00;
  localparam logic [BUS_W-1:0] BUS_ZERO = 8'h00;

  // sector length in servo clock rising edges, per switch setting
  localparam logic [SECT_W-1:0] SECT_LEN_0 = 16'h0080;
  localparam logic [SECT_W-1:0] SECT_LEN_1 = 16'h0100;
  localparam logic [SECT_W-1:0] SECT_LEN_2 = 16'h0200;
  localparam logic [SECT_W-1:0] SECT_LEN_3 = 16'h0400;

  localparam logic [2:0] HEAD_MAX = 3'h4;
  localparam logic [2:0] HEAD_DEFAULT = 3'h0;

  typedef enum logic [BUS_W-1:0] {
    CMD_SEEK = 8'h01,
    CMD_RESTORE = 8'h02,
    CMD_FAULT_CLR = 8'h03,
    CMD_SPIN_UP = 8'h04,
    CMD_SPIN_DOWN = 8'h05
  } ddh_cmd_t;

  typedef enum logic [1:0] {
    CARR_IDLE = 2'b00,
    CARR_SEEK = 2'b01,
    CARR_RESTORE = 2'b10
  } ddh_carr_t;

endpackage

// >>> bench/ddh_ctrl_model.sv
// Purpose: controller side of the serial write path
// Assumes: reference clock comes back from the drive
// Notes: echoes the clock and sends a rotating byte
`timescale 1ns/1ps
module ddh_ctrl_model (
  input wire logic ref_clk,
  output logic write_clk,
  output logic write_data
);
  logic [7:0] pat_r = 8'hA5;
  // echoed reference clock
  assign write_clk = ref_clk;
  // nrz bit moves on the rise, stable over the fall
  always @(posedge ref_clk)
    pat_r <= {pat_r[6:0], pat_r[7]};
  assign write_data = pat_r[7];
endmodule

// >>> bench/ddh_drive_if_props.sv
// Purpose: port assertions for the drive host port
// Assumes: pins change just after core_clk rises
// Notes: pin to output lag is two to four cycles
`timescale 1ns/1ps
module ddh_drive_if_props (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic rd_n,
  input wire logic [3:0] drive_select_n,
  input wire logic [1:0] sw_drive_addr,
  input wire logic host_data_bus_oe,
  input wire logic read_gate_n,
  input wire logic pll_acquire,
  input wire logic read_data,
  input wire logic read_ref_clk,
  input wire logic data_recovery_oscillator_clk,
  input wire logic [2:0] head_select_n,
  input wire logic [2:0] head_sel,
  input wire logic write_gate_n,
  input wire logic sw_write_protect,
  input wire logic write_current_en,
  input wire logic drive_fault,
  input wire logic spindle_run,
  input wire logic ready_n_oe,
  input wire logic index_n_oe
);
  logic sel;
  logic [2:0] code;
  logic [7:0] acq_r;
  assign sel = !drive_select_n[sw_drive_addr];
  assign code = ~head_select_n;
  // cycles since acquisition began
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      acq_r <= 8'h00;
    else
      acq_r <= !pll_acquire ? 8'h00 : acq_r + {7'h00, acq_r != 8'hFF};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_head_steady;
    (sel && $stable(head_select_n)) [*5];
  endsequence
  sequence s_prot_write;
    (sel && !write_gate_n && sw_write_protect) [*4];
  endsequence
  a_read_drive: assert property (
    $fell(rd_n) && sel |-> ##[2:5] host_data_bus_oe)
    else $error("bus not driven in a read");
  a_bus_release: assert property (
    host_data_bus_oe |->
      !$past(rd_n, 2) || !$past(rd_n, 3) || !$past(rd_n, 4))
    else $error("bus driven without a read");
  a_unsel_quiet: assert property (
    !sel [*5] |-> !host_data_bus_oe && !pll_acquire && !write_current_en
      && !ready_n_oe && !index_n_oe)
    else $error("unselected drive responds");
  a_ready_cause: assert property (
    ready_n_oe |-> $past(spindle_run) && !$past(drive_fault))
    else $error("ready without spin or with fault");
  a_acquire_on: assert property (
    $fell(read_gate_n) && sel |-> ##[2:5] pll_acquire)
    else $error("read gate did not start lock");
  a_read_invalid: assert property (
    read_data && pll_acquire |-> acq_r >= 8'h56)
    else $error("read data too early");
  a_ref_osc: assert property (
    acq_r >= 8'h46 |->
      read_ref_clk == $past(data_recovery_oscillator_clk, 2)
      || read_ref_clk == $past(data_recovery_oscillator_clk, 3)
      || read_ref_clk == $past(data_recovery_oscillator_clk, 4))
    else $error("reference clock not from oscillator");
  a_head_decode: assert property (
    s_head_steady |-> head_sel == ((code > 3'h4) ? 3'h0 : code))
    else $error("head decode wrong");
  a_write_gate: assert property (
    write_current_en |-> !sw_write_protect && !drive_fault &&
      (!$past(write_gate_n, 2) || !$past(write_gate_n, 3)
      || !$past(write_gate_n, 4)))
    else $error("write current without gate");
  a_prot_fault: assert property (
    s_prot_write |-> ##[0:3] drive_fault)
    else $error("protected write gave no fault");
  a_index_width: assert property (
    $rose(index_n_oe) |=> index_n_oe ##1 !index_n_oe)
    else $error("index pulse width wrong");
endmodule

bind ddh_drive_if ddh_drive_if_props ddh_drive_if_props_i (.*);

// >>> bench/testbench.sv
// Purpose: self-checking bench for the drive host port
// Assumes: drive answers select line 2, sector switch 0
// Notes: servo clock 800 ns, oscillator 600 ns
`timescale 1ns/1ps
module testbench;
  import ddh_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, rd_n = 1'b1, wr_n = 1'b1;
  logic host_reset_n = 1'b1, write_gate_n = 1'b1, read_gate_n = 1'b1;
  logic servo_clk = 1'b0, servo_index = 1'b0, spindle_at_speed = 1'b0;
  logic data_recovery_oscillator_clk = 1'b0;
  logic data_recovery_oscillator_data = 1'b0;
  logic sw_write_protect = 1'b0, sw_wclk_from_drive = 1'b0;
  logic [7:0] tb_bus = 8'h00, host_data_bus_in, host_data_bus_out, rd_v;
  logic [1:0] register_select_lines = 2'h0, sw_drive_addr = 2'h2;
  logic [1:0] sw_sector_len = 2'h0;
  logic [3:0] drive_select_n = 4'hB;
  logic [2:0] head_select_n = 3'h7, head_sel;
  logic host_data_bus_oe, write_clk_in, write_data, write_clk_out;
  logic write_clk_oe, ready_n_out, ready_n_oe, index_n_out, index_n_oe;
  logic sector_mark_n_out, sector_mark_n_oe, read_ref_clk, read_data;
  logic pll_acquire, write_current_en, write_bit, write_bit_stb;
  logic spindle_run, drive_fault, oe_seen;
  int failures = 0, n_tests = 0, tk = 0, stb_cnt = 0, ones_cnt = 0, i, j, k;
  // wire level seen by the drive
  assign host_data_bus_in = host_data_bus_oe ? host_data_bus_out : tb_bus;
  initial
    forever #50 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    tk <= tk + 1;
    stb_cnt <= stb_cnt + int'(write_bit_stb);
    ones_cnt <= ones_cnt + int'(write_bit_stb & write_bit);
    servo_clk <= (tk % 8) < 4;
    servo_index <= (tk % 4096) < 8;
    data_recovery_oscillator_clk <= (tk % 6) < 3;
    data_recovery_oscillator_data <= tk[4];
  end
  ddh_drive_if ddh_drive_if_i (.*);
  ddh_ctrl_model ddh_ctrl_model_i (
    .ref_clk(read_ref_clk),
    .write_clk(write_clk_in),
    .write_data(write_data)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic sig(input int id);
    case (id)
      0: return ready_n_oe;
      1: return index_n_oe;
      2: return sector_mark_n_oe;
      default: return drive_fault;
    endcase
  endfunction
  task automatic wait_sig(input int id, input logic v, input int n);
    for (j = 0; j < n && sig(id) !== v; j++)
      cyc(1);
    chk({7'h00, sig(id)}, {7'h00, v});
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    register_select_lines <= a;
    tb_bus <= d;
    wr_n <= 1'b0;
    cyc(5);
    wr_n <= 1'b1;
    cyc(4);
    tb_bus <= ~d;
  endtask
  task automatic rd_reg(input logic [1:0] a);
    register_select_lines <= a;
    rd_n <= 1'b0;
    oe_seen = 1'b0;
    for (j = 0; j < 8; j++)
    begin
      cyc(1);
      oe_seen = oe_seen | (host_data_bus_oe === 1'b1);
    end
    rd_v = host_data_bus_in;
    rd_n <= 1'b1;
    cyc(6);
  endtask
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
    rd_reg(a);
    chk(rd_v, exp);
    chk({7'h00, host_data_bus_oe}, 8'h00);
  endtask
  task automatic end_sim;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(40000);
    failures++;
    $display("CHECK FAILED t=%0t watchdog", $time);
    end_sim();
  end
  initial
  begin
    cyc(10);
    rst_n <= 1'b1;
    cyc(4);
    rd_chk(REG_CMD, 8'h00);
    rd_chk(2'h3, 8'h00);
    drive_select_n <= 4'hF;
    wr_reg(REG_CMD, CMD_SPIN_UP);
    chk({7'h00, spindle_run}, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      drive_select_n <= ~(4'h1 << i);
      rd_reg(REG_CMD);
      chk({7'h00, oe_seen}, {7'h00, i == 2});
    end
    drive_select_n <= 4'hB;
    cyc(4);
    wr_reg(REG_CMD, CMD_SPIN_UP);
    cyc(20);
    chk({7'h00, ready_n_oe}, 8'h00);
    spindle_at_speed <= 1'b1;
    wait_sig(0, 1'b1, 100);
    rd_chk(REG_CMD, 8'h09);
    wr_reg(REG_CYL, 8'h03);
    rd_chk(REG_CYL, 8'h03);
    wr_reg(REG_CMD, CMD_SEEK);
    chk({7'h00, ready_n_oe}, 8'h00);
    wait_sig(0, 1'b1, 300);
    rd_chk(REG_POS, 8'h03);
    for (i = 0; i < 8; i++)
    begin
      head_select_n <= ~i[2:0];
      cyc(6);
      chk({5'h00, head_sel}, (i > 4) ? 8'h00 : i[7:0]);
    end
    drive_select_n <= 4'hF;
    head_select_n <= 3'h6;
    cyc(6);
    chk({5'h00, head_sel}, 8'h00);
    drive_select_n <= 4'hB;
    head_select_n <= 3'h7;
    read_gate_n <= 1'b0;
    cyc(40);
    chk({7'h00, read_data}, 8'h00);
    chk({7'h00, pll_acquire}, 8'h01);
    cyc(60);
    rd_chk(REG_CMD, 8'h29);
    read_gate_n <= 1'b1;
    wait_sig(2, 1'b1, 5000);
    i = stb_cnt;
    k = ones_cnt;
    write_gate_n <= 1'b0;
    cyc(60);
    chk({7'h00, write_current_en}, 8'h01);
    chk({7'h00, stb_cnt > i}, 8'h01);
    chk({7'h00, ones_cnt > k}, 8'h01);
    chk({7'h00, stb_cnt - i > ones_cnt - k}, 8'h01);
    write_gate_n <= 1'b1;
    wait_sig(1, 1'b1, 5000);
    write_gate_n <= 1'b0;
    wait_sig(3, 1'b1, 10);
    chk({7'h00, write_current_en}, 8'h00);
    write_gate_n <= 1'b1;
    cyc(4);
    wr_reg(REG_CMD, CMD_FAULT_CLR);
    wait_sig(3, 1'b0, 20);
    wait_sig(1, 1'b1, 5000);
    for (i = 0; i < 1100 && sector_mark_n_oe !== 1'b1; i++)
      cyc(1);
    chk({7'h00, i > 1010 && i < 1040}, 8'h01);
    sw_write_protect <= 1'b1;
    write_gate_n <= 1'b0;
    wait_sig(3, 1'b1, 20);
    write_gate_n <= 1'b1;
    rd_chk(REG_CMD, 8'h1A);
    sw_write_protect <= 1'b0;
    wr_reg(REG_CMD, CMD_FAULT_CLR);
    host_reset_n <= 1'b0;
    cyc(5);
    host_reset_n <= 1'b1;
    cyc(5);
    chk({7'h00, spindle_run}, 8'h01);
    wait_sig(0, 1'b1, 300);
    rd_chk(REG_POS, 8'h00);
    wr_reg(REG_CMD, CMD_SPIN_DOWN);
    host_reset_n <= 1'b0;
    cyc(5);
    host_reset_n <= 1'b1;
    cyc(10);
    chk({7'h00, spindle_run}, 8'h00);
    sw_wclk_from_drive <= 1'b1;
    cyc(5);
    chk({7'h00, write_clk_oe}, 8'h01);
    chk({7'h00, write_clk_out}, {7'h00, read_ref_clk});
    end_sim();
  end
endmodule
